// [sim/tcc_pin_model.sv]
// Far-side driver of the two capture input pins
module tcc_pin_model (
	input  wire logic sys_clk,
	input  wire logic lvlOne,
	input  wire logic lvlTwo,
	output logic      capPinOne = 1'b0,
	output logic      capPinTwo = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Step just after the edge, as an outside signal unrelated to sampling
	always @(posedge sys_clk) begin
		capPinOne <= #1 lvlOne;
		capPinTwo <= #1 lvlTwo;
	end
endmodule // tcc_pin_model

// [sim/tcc_timer_asserts.sv]
// Port checker for the timer capture/compare block
module tcc_timer_asserts #(
	parameter int ADDR_W = 8
) (
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              compareOutPinOne,
	input wire logic              compareOutPinTwo,
	input wire logic              timerIrq
);
	logic wrTake;
	logic enTwo_r;
	logic enTwo_nxt;
	// Address and data are always offered together, so one handshake marks it
	assign wrTake = s_axi_awvalid && s_axi_awready;
	always_comb begin
		enTwo_nxt = enTwo_r;
		if (wrTake && s_axi_awaddr == 8'h04 && s_axi_wstrb[0])
			enTwo_nxt = s_axi_wdata[1];
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			enTwo_r <= 1'b0;
		else
			enTwo_r <= enTwo_nxt;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	rst_quiet_a: assert property ($past(rst) |-> !timerIrq &&
		!compareOutPinOne && !compareOutPinTwo) else $error("reset leak");
	wr_answer_a: assert property (wrTake |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	wr_unmapped_a: assert property (wrTake && s_axi_awaddr > 8'h28
		|-> ##2 s_axi_bresp == 2'h2) else $error("bad write resp");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > 8'h28 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
		else $error("bad read resp");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read overlap");
	pin_frozen_a: assert property (!enTwo_r && !$past(enTwo_r) &&
		!$past(enTwo_r, 2) |-> $stable(compareOutPinTwo))
		else $error("pin two moved while disabled");
	cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28);
	cover property ($rose(timerIrq));
	cover property ($rose(compareOutPinTwo));
endmodule // tcc_timer_asserts

bind tcc_timer_top tcc_timer_asserts #(.ADDR_W(ADDR_W)) checker_i (
	.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compareOutPinOne,
	.compareOutPinTwo, .timerIrq);

// [sim/timer_capture_compare_control_test.sv]
// Self-checking bench for the timer capture/compare block
module timer_capture_compare_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 0, rst = 1, lvlOne = 0, lvlTwo = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, v;
	logic [3:0]  s_axi_wstrb = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, timerIrq;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        captureInPinOne, captureInPinTwo;
	logic        compareOutPinOne, compareOutPinTwo;
	int          fails = 0, checkCount = 0, cycles = 0;

	initial forever #2 sys_clk = ~sys_clk;

	tcc_timer_top #(.ADDR_W(8)) DUT (.sys_clk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.captureInPinOne, .captureInPinTwo, .compareOutPinOne,
		.compareOutPinTwo, .timerIrq);
	tcc_pin_model PINS (.sys_clk, .lvlOne, .lvlTwo,
		.capPinOne(captureInPinOne), .capPinTwo(captureInPinTwo));

	task automatic close_out();
		if (fails == 0 && checkCount > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkB(input logic got, input logic exp);
		chkW({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdw(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
		rdw(a);
		chkW(rd & m, e);
	endtask
	// Place a compare value just ahead of the running count, then let it hit
	task automatic arm(input logic [7:0] a);
		rdw(8'h14);
		// Compare registers hold 16 bits; keep the expected value in range
		v = (rd + 32'd30) & 32'h0000FFFF;
		wr(a, v);
		rc(a, 32'hFFFFFFFF, v);
		repeat (40) @(posedge sys_clk);
	endtask
	task automatic settle();
		repeat (10) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		chkB(timerIrq, 1'b0);
		rc(8'h00, 32'hFF, 32'h00);
		wr(8'h00, 32'hE6);
		rc(8'h00, 32'hFF, 32'hE6);
		wr(8'h40, 32'h1);
		chkW(32'(rsp), 32'h2);
		rc(8'h40, 32'hFFFFFFFF, 32'h0);
		chkW(32'(rsp), 32'h2);
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h05);
		chkB(compareOutPinOne, 1'b0);
		wr(8'h00, 32'h1D);
		chkB(compareOutPinOne, 1'b1);
		chkB(compareOutPinTwo, 1'b1);
		wr(8'h00, 32'h18);
		chkB(compareOutPinTwo, 1'b0);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h1D);
		chkB(compareOutPinOne, 1'b0);
		wr(8'h04, 32'h3);
		wr(8'h10, 32'h1F);
		wr(8'h00, 32'h45);
		wr(8'h0C, 32'h1F);
		chkB(timerIrq, 1'b0);
		arm(8'h1C);
		chkB(compareOutPinOne, 1'b1);
		chkB(compareOutPinTwo, 1'b0);
		chkB(timerIrq, 1'b1);
		wr(8'h00, 32'h05);
		chkB(timerIrq, 1'b0);
		arm(8'h20);
		chkB(compareOutPinTwo, 1'b1);
		for (int i = 0; i < 2; i++) begin
			// Pin two stays enabled so a wrong route to it would show
			wr(8'h04, i ? 32'hB : 32'h7);
			wr(8'h00, i ? 32'h4 : 32'h0);
			arm(8'h20);
			chkB(compareOutPinOne, i[0]);
			chkB(compareOutPinTwo, 1'b1);
		end
		wr(8'h0C, 32'h1F);
		wr(8'h00, 32'h80);
		lvlOne <= 1'b1;
		settle();
		rc(8'h08, 32'h1, 32'h0);
		chkB(timerIrq, 1'b0);
		lvlOne <= 1'b0;
		settle();
		rc(8'h08, 32'h1, 32'h1);
		chkB(timerIrq, 1'b1);
		wr(8'h0C, 32'h1F);
		wr(8'h00, 32'h82);
		lvlOne <= 1'b1;
		lvlTwo <= 1'b1;
		settle();
		rc(8'h08, 32'h3, 32'h3);
		wr(8'h00, 32'h00);
		chkB(timerIrq, 1'b0);
		wr(8'h00, 32'h20);
		rdw(8'h14);
		repeat (32'h10000 - rd + 8) @(posedge sys_clk);
		rc(8'h08, 32'h10, 32'h10);
		chkB(timerIrq, 1'b1);
		wr(8'h00, 32'h00);
		chkB(timerIrq, 1'b0);
		close_out();
	end
endmodule // timer_capture_compare_control_test

// [verilog/tcc_capture_unit.sv]
// Input capture channel: pin synchroniser, edge select and value latch
`include "tcc_consts.svh"
module tcc_capture_unit (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              capPin,
	input  wire logic              risingSel,
	input  wire tcc_pkg::tcc_word_t count,
	output logic                   capEvent,
	output tcc_pkg::tcc_word_t     capValue
);
	import tcc_pkg::*;

	logic      sync1_r;
	logic      sync2_r;
	logic      prev_r;
	logic      event_r;
	logic      event_nxt;
	tcc_word_t value_r;
	tcc_word_t value_nxt;

	always_comb begin
		// Only the second stage and its delayed copy feed the edge test
		if (risingSel) begin
			event_nxt = sync2_r && !prev_r;
		end else begin
			event_nxt = !sync2_r && prev_r;
		end
		value_nxt = event_nxt ? count : value_r;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
			event_r <= 1'b0;
			value_r <= `TCC_WORD_RST;
		end else begin
			sync1_r <= capPin;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
			event_r <= event_nxt;
			value_r <= value_nxt;
		end
	end

	assign capEvent = event_r;
	assign capValue = value_r;
endmodule // tcc_capture_unit

// [verilog/tcc_compare_unit.sv]
// Output compare channel: registered match of counter against value
`include "tcc_consts.svh"
module tcc_compare_unit (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire tcc_pkg::tcc_word_t count,
	input  wire tcc_pkg::tcc_word_t value,
	output logic                    match
);
	import tcc_pkg::*;

	logic match_r;
	logic match_nxt;

	always_comb begin
		match_nxt = (count == value);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			match_r <= 1'b0;
		end else begin
			match_r <= match_nxt;
		end
	end

	assign match = match_r;
endmodule // tcc_compare_unit

// [verilog/tcc_consts.svh]
// Offsets, field positions, reset values and codes of the timer block
// Behaviour
// - Control/status registers plus three sixteen-bit data pairs
// - Capture enable gates interrupt from capture flags
// - Compare enable gates interrupt from compare flags
// - Overflow enable gates interrupt from overflow flag
// - Force two copies level two to pin two
// - Force one copies level one to pin one
// - Compare-two match drives level two onto pin two outside the pulse modes
// - Pulse modes route level two to pin one
// - Edge bit picks falling or rising edge for capture one; capture two is rising only
// - Compare-one match drives level one onto pin one
// - Control register one is read/write, resets zero
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_OFF_CTRL_ONE   8'h00
`define TCC_OFF_CTRL_TWO   8'h04
`define TCC_OFF_STATUS     8'h08
`define TCC_OFF_CLEAR      8'h0C
`define TCC_OFF_IRQ_EN     8'h10
`define TCC_OFF_COUNT      8'h14
`define TCC_OFF_ALT_COUNT  8'h18
`define TCC_OFF_CMP_ONE    8'h1C
`define TCC_OFF_CMP_TWO    8'h20
`define TCC_OFF_CAP_ONE    8'h24
`define TCC_OFF_CAP_TWO    8'h28

`define TCC_C1_CAP_IE      7
`define TCC_C1_CMP_IE      6
`define TCC_C1_OVF_IE      5
`define TCC_C1_FORCE_TWO   4
`define TCC_C1_FORCE_ONE   3
`define TCC_C1_LEVEL_TWO   2
`define TCC_C1_EDGE_ONE    1
`define TCC_C1_LEVEL_ONE   0

`define TCC_C2_OUT_ONE_EN  0
`define TCC_C2_OUT_TWO_EN  1
`define TCC_C2_ONE_PULSE   2
`define TCC_C2_PWM         3

`define TCC_ST_CAP_ONE     0
`define TCC_ST_CAP_TWO     1
`define TCC_ST_CMP_ONE     2
`define TCC_ST_CMP_TWO     3
`define TCC_ST_OVF         4

`define TCC_CTRL_ONE_RST   8'h00
`define TCC_CTRL_TWO_RST   4'h0
`define TCC_STATUS_RST     5'h00
`define TCC_WORD_RST       16'h0000
`define TCC_CNT_MAX        16'hFFFF
`define TCC_RESP_OKAY      2'h0
`define TCC_RESP_SLVERR    2'h2

`endif

// [verilog/tcc_pkg.sv]
// Types shared by the timer capture/compare files
package tcc_pkg;
	typedef logic [15:0] tcc_word_t;
	typedef logic [7:0]  tcc_byte_t;
	typedef logic [4:0]  tcc_flags_t;
	typedef enum {TCC_OUT_NORMAL, TCC_OUT_PULSE} tcc_outmode_t;
endpackage

// [verilog/tcc_timer_top.sv]
// Timer capture/compare control block with AXI4-Lite register slave
//
// The AXI4-Lite register port and the address map were left to the implementer.
`include "tcc_consts.svh"
module tcc_timer_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              captureInPinOne,
	input  wire logic              captureInPinTwo,
	output logic                   compareOutPinOne,
	output logic                   compareOutPinTwo,
	output logic                   timerIrq
);
	import tcc_pkg::*;

	// Bus write side
	logic              awHeld_r;
	logic              awHeld_nxt;
	logic [ADDR_W-1:0] awAddr_r;
	logic [ADDR_W-1:0] awAddr_nxt;
	logic              wHeld_r;
	logic              wHeld_nxt;
	logic [31:0]       wData_r;
	logic [31:0]       wData_nxt;
	logic [3:0]        wStrb_r;
	logic [3:0]        wStrb_nxt;
	logic              bvalid_r;
	logic              bvalid_nxt;
	logic [1:0]        bresp_r;
	logic [1:0]        bresp_nxt;
	logic              doWrite;
	logic              wrHit;

	// Bus read side
	logic              rvalid_r;
	logic              rvalid_nxt;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic [1:0]        rresp_r;
	logic [1:0]        rresp_nxt;

	// Timer state
	tcc_byte_t         ctrlOne_r;
	tcc_byte_t         ctrlOne_nxt;
	logic [3:0]        ctrlTwo_r;
	logic [3:0]        ctrlTwo_nxt;
	tcc_flags_t        status_r;
	tcc_flags_t        status_nxt;
	tcc_flags_t        irqEn_r;
	tcc_flags_t        irqEn_nxt;
	tcc_flags_t        statusSet;
	tcc_flags_t        statusClr;
	tcc_flags_t        groupEn;
	tcc_word_t         count_r;
	tcc_word_t         count_nxt;
	tcc_word_t         cmpVal_r [2];
	tcc_word_t         cmpVal_nxt [2];
	tcc_word_t         capVal [2];
	logic [1:0]        capEvent;
	logic [1:0]        cmpMatch;
	logic [1:0]        edgeSel;
	logic [1:0]        capPins;
	logic              overflow;
	logic              pinOne_r;
	logic              pinOne_nxt;
	logic              pinTwo_r;
	logic              pinTwo_nxt;
	logic              forceOne;
	logic              forceTwo;
	tcc_outmode_t      outMode;

	function automatic tcc_word_t mergeWord(tcc_word_t old,
		logic [31:0] data, logic [3:0] strb);
		tcc_word_t res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// Capture channel two always triggers on rising edges
	assign edgeSel = {1'b1, ctrlOne_r[`TCC_C1_EDGE_ONE]};
	assign capPins = {captureInPinTwo, captureInPinOne};

	for (genvar ch = 0; ch < 2; ch++) begin : gChan
		tcc_capture_unit uCap (
			.sys_clk   (sys_clk),
			.rst       (rst),
			.capPin    (capPins[ch]),
			.risingSel (edgeSel[ch]),
			.count     (count_r),
			.capEvent  (capEvent[ch]),
			.capValue  (capVal[ch])
		);
		tcc_compare_unit uCmp (
			.sys_clk (sys_clk),
			.rst     (rst),
			.count   (count_r),
			.value   (cmpVal_r[ch]),
			.match   (cmpMatch[ch])
		);
	end

	// AXI write channel: address and data held until both have arrived
	always_comb begin
		awHeld_nxt = awHeld_r;
		awAddr_nxt = awAddr_r;
		wHeld_nxt  = wHeld_r;
		wData_nxt  = wData_r;
		wStrb_nxt  = wStrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		doWrite    = awHeld_r && wHeld_r && !bvalid_r;
		unique case (awAddr_r)
			`TCC_OFF_CTRL_ONE, `TCC_OFF_CTRL_TWO, `TCC_OFF_CLEAR,
			`TCC_OFF_IRQ_EN, `TCC_OFF_CMP_ONE, `TCC_OFF_CMP_TWO,
			`TCC_OFF_STATUS, `TCC_OFF_COUNT, `TCC_OFF_ALT_COUNT,
			`TCC_OFF_CAP_ONE, `TCC_OFF_CAP_TWO: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
		if (s_axi_awvalid && !awHeld_r) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_r) begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (doWrite) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = wrHit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
		end
	end

	// AXI read channel: one read at a time, answer on the next cycle
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = `TCC_RESP_OKAY;
			rdata_nxt  = 32'h0000_0000;
			unique case (s_axi_araddr)
				`TCC_OFF_CTRL_ONE:  rdata_nxt[7:0]  = ctrlOne_r;
				`TCC_OFF_CTRL_TWO:  rdata_nxt[3:0]  = ctrlTwo_r;
				`TCC_OFF_STATUS:    rdata_nxt[4:0]  = status_r;
				`TCC_OFF_CLEAR:     rdata_nxt       = 32'h0000_0000;
				`TCC_OFF_IRQ_EN:    rdata_nxt[4:0]  = irqEn_r;
				// Both counter views show the one free-running count
				`TCC_OFF_COUNT:     rdata_nxt[15:0] = count_r;
				`TCC_OFF_ALT_COUNT: rdata_nxt[15:0] = count_r;
				`TCC_OFF_CMP_ONE:   rdata_nxt[15:0] = cmpVal_r[0];
				`TCC_OFF_CMP_TWO:   rdata_nxt[15:0] = cmpVal_r[1];
				`TCC_OFF_CAP_ONE:   rdata_nxt[15:0] = capVal[0];
				`TCC_OFF_CAP_TWO:   rdata_nxt[15:0] = capVal[1];
				default:            rresp_nxt = `TCC_RESP_SLVERR;
			endcase
		end
	end

	// Register file, counter and status flags
	always_comb begin
		ctrlOne_nxt = ctrlOne_r;
		ctrlTwo_nxt = ctrlTwo_r;
		irqEn_nxt   = irqEn_r;
		cmpVal_nxt  = cmpVal_r;
		statusClr   = `TCC_STATUS_RST;
		forceOne    = 1'b0;
		forceTwo    = 1'b0;
		count_nxt   = 16'(count_r + 16'h0001);
		overflow    = (count_r == `TCC_CNT_MAX);
		if (doWrite && wStrb_r[0]) begin
			unique case (awAddr_r)
				`TCC_OFF_CTRL_ONE: begin
					ctrlOne_nxt = wData_r[7:0];
					forceOne = wData_r[`TCC_C1_FORCE_ONE];
					forceTwo = wData_r[`TCC_C1_FORCE_TWO];
				end
				`TCC_OFF_CTRL_TWO: ctrlTwo_nxt = wData_r[3:0];
				`TCC_OFF_CLEAR:    statusClr   = wData_r[4:0];
				`TCC_OFF_IRQ_EN:   irqEn_nxt   = wData_r[4:0];
				default: ;
			endcase
		end
		if (doWrite && awAddr_r == `TCC_OFF_CMP_ONE) begin
			cmpVal_nxt[0] = mergeWord(cmpVal_r[0], wData_r, wStrb_r);
		end
		if (doWrite && awAddr_r == `TCC_OFF_CMP_TWO) begin
			cmpVal_nxt[1] = mergeWord(cmpVal_r[1], wData_r, wStrb_r);
		end
		statusSet = '0;
		statusSet[`TCC_ST_CAP_ONE] = capEvent[0];
		statusSet[`TCC_ST_CAP_TWO] = capEvent[1];
		statusSet[`TCC_ST_CMP_ONE] = cmpMatch[0];
		statusSet[`TCC_ST_CMP_TWO] = cmpMatch[1];
		statusSet[`TCC_ST_OVF]     = overflow;
		// A flag event in the clearing cycle survives the clear
		status_nxt = (status_r & ~statusClr) | statusSet;
	end

	// Each flag reaches the line only if its group enable is also set
	always_comb begin
		groupEn = '0;
		groupEn[`TCC_ST_CAP_ONE] = ctrlOne_r[`TCC_C1_CAP_IE];
		groupEn[`TCC_ST_CAP_TWO] = ctrlOne_r[`TCC_C1_CAP_IE];
		groupEn[`TCC_ST_CMP_ONE] = ctrlOne_r[`TCC_C1_CMP_IE];
		groupEn[`TCC_ST_CMP_TWO] = ctrlOne_r[`TCC_C1_CMP_IE];
		groupEn[`TCC_ST_OVF]     = ctrlOne_r[`TCC_C1_OVF_IE];
	end

	assign timerIrq = |(status_r & irqEn_r & groupEn);

	// Output pins; forced copies use the level being written alongside
	always_comb begin
		pinOne_nxt = pinOne_r;
		pinTwo_nxt = pinTwo_r;
		if (ctrlTwo_r[`TCC_C2_ONE_PULSE] || ctrlTwo_r[`TCC_C2_PWM]) begin
			outMode = TCC_OUT_PULSE;
		end else begin
			outMode = TCC_OUT_NORMAL;
		end
		// Disabled outputs keep their level untouched
		if (ctrlTwo_r[`TCC_C2_OUT_ONE_EN]) begin
			if (cmpMatch[0]) begin
				pinOne_nxt = ctrlOne_r[`TCC_C1_LEVEL_ONE];
			end
			if (outMode == TCC_OUT_PULSE && cmpMatch[1]) begin
				pinOne_nxt = ctrlOne_r[`TCC_C1_LEVEL_TWO];
			end
			if (forceOne) begin
				pinOne_nxt = ctrlOne_nxt[`TCC_C1_LEVEL_ONE];
			end
		end
		if (ctrlTwo_r[`TCC_C2_OUT_TWO_EN]) begin
			if (outMode == TCC_OUT_NORMAL && cmpMatch[1]) begin
				pinTwo_nxt = ctrlOne_r[`TCC_C1_LEVEL_TWO];
			end
			if (forceTwo) begin
				pinTwo_nxt = ctrlOne_nxt[`TCC_C1_LEVEL_TWO];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awHeld_r <= 1'b0;
			awAddr_r <= '0;
			wHeld_r  <= 1'b0;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r  <= `TCC_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `TCC_RESP_OKAY;
		end else begin
			awHeld_r <= awHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wHeld_r  <= wHeld_nxt;
			wData_r  <= wData_nxt;
			wStrb_r  <= wStrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlOne_r   <= `TCC_CTRL_ONE_RST;
			ctrlTwo_r   <= `TCC_CTRL_TWO_RST;
			status_r    <= `TCC_STATUS_RST;
			irqEn_r     <= `TCC_STATUS_RST;
			count_r     <= `TCC_WORD_RST;
			cmpVal_r[0] <= `TCC_WORD_RST;
			cmpVal_r[1] <= `TCC_WORD_RST;
			pinOne_r    <= 1'b0;
			pinTwo_r    <= 1'b0;
		end else begin
			ctrlOne_r   <= ctrlOne_nxt;
			ctrlTwo_r   <= ctrlTwo_nxt;
			status_r    <= status_nxt;
			irqEn_r     <= irqEn_nxt;
			count_r     <= count_nxt;
			cmpVal_r    <= cmpVal_nxt;
			pinOne_r    <= pinOne_nxt;
			pinTwo_r    <= pinTwo_nxt;
		end
	end

	assign s_axi_awready    = !awHeld_r;
	assign s_axi_wready     = !wHeld_r;
	assign s_axi_bvalid     = bvalid_r;
	assign s_axi_bresp      = bresp_r;
	assign s_axi_arready    = !rvalid_r;
	assign s_axi_rvalid     = rvalid_r;
	assign s_axi_rdata      = rdata_r;
	assign s_axi_rresp      = rresp_r;
	assign compareOutPinOne = pinOne_r;
	assign compareOutPinTwo = pinTwo_r;
endmodule // tcc_timer_top
